// ==== dv/trst_chan_model.sv ====
/* trst_chan_model: channel side of trst_top (power, locks, source clock).
   Assumes it shares clk_in and rst_in with the design. */
`timescale 1ns/1ns
`default_nettype none
module trst_chan_model (
	// clock, reset and commands
	input  wire logic				clk_in,
	input  wire logic				rst_in,
	input  wire logic				pll_reset_in,
	input  wire logic				tx_drop_in,
	input  wire logic				rx_drop_in,
	// channel status
	output logic [trst_pkg::NUM_CH-1:0]	ch_powergood_out,
	output logic				tx_lock_out,
	output logic				rx_lock_out,
	output logic [trst_pkg::NUM_CH-1:0]	outclk_en_out,
	output logic				rx_active_out
);
	// =====================================================================
	// power-up timer, pll lock timer, source clock enable
	logic [7:0]	up_q;
	logic [3:0]	lk_q;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			up_q <= 8'h00;
			lk_q <= 4'h0;
			outclk_en_out <= '0;
		end else begin
			up_q <= (up_q == 8'hFF) ? up_q : up_q + 8'h01;
			lk_q <= pll_reset_in ? 4'h0 : lk_q + {3'h0, !lk_q[3]};
			// only the master channel runs, so a wrong pick shows up
			outclk_en_out <= trst_pkg::NUM_CH'(!outclk_en_out[0]);
		end
	end
	// power comes late; locks only after pll reset is let go
	assign ch_powergood_out = (up_q > 8'h0A) ? '1 : '0;
	assign tx_lock_out = lk_q[3] && !tx_drop_in;
	assign rx_lock_out = lk_q[3] && !rx_drop_in;
	assign rx_active_out = up_q > 8'h20;
endmodule // trst_chan_model
`default_nettype wire

// ==== dv/trst_checker.sv ====
/* trst_checker: port assertions for trst_top.
   Assumes a bind onto trst_top; every port is on clk_in. */
`timescale 1ns/1ns
`default_nettype none
module trst_checker #(
	parameter int unsigned PG_DELAY_CYCLES = 4
) (
	// clock, reset and inputs
	input wire logic				clk_in,
	input wire logic				rst_in,
	input wire logic				reset_all_in,
	input wire logic				reset_tx_in,
	input wire logic				reset_rx_in,
	input wire logic [trst_pkg::NUM_CH-1:0]	ch_powergood_in,
	input wire logic				tx_pll_lock_in,
	input wire logic				rx_pll_lock_in,
	input wire logic				userclk_tx_reset_in,
	// outputs and the channel source clock enables
	input wire logic [trst_pkg::NUM_CH-1:0]	powergood_out,
	input wire logic				pll_reset_out,
	input wire logic				tx_done_out,
	input wire logic				rx_done_out,
	input wire logic				tx_bypass_start_out,
	input wire logic				tx_user_ready_out,
	input wire logic				tx_userclk_active_out,
	input wire logic				tx_datapath_clock_out,
	input wire logic				tx_interface_clock_out,
	input wire logic [trst_pkg::NUM_CH-1:0]	tx_outclk_en_in,
	input wire logic				tx_srcclk_out
);
	// =====================================================================
	// port relations
	wire logic req_any = reset_all_in || reset_tx_in || reset_rx_in;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	a_pll_pg_hold: assert property (
		!(&powergood_out) |-> pll_reset_out) else $error("pll reset early");
	a_pg_delay: assert property (
		$rose(powergood_out[0]) |-> $past(&ch_powergood_in, PG_DELAY_CYCLES))
		else $error("power good not delayed");
	a_tx_lock_loss: assert property (
		!tx_pll_lock_in |=> !tx_done_out) else $error("tx done kept");
	a_rx_lock_loss: assert property (
		!rx_pll_lock_in |=> !rx_done_out) else $error("rx done kept");
	a_no_restart: assert property (
		$rose(pll_reset_out) |-> $past(req_any) || $past(req_any, 2))
		else $error("reset pass without request");
	a_bypass_pulse: assert property (
		tx_bypass_start_out |-> $rose(tx_done_out) ##1 !tx_bypass_start_out)
		else $error("bad bypass start");
	a_ready_clk: assert property (
		$rose(tx_user_ready_out) |-> $past(tx_userclk_active_out))
		else $error("ready before clock");
	a_helper_rst: assert property (
		userclk_tx_reset_in |=> !tx_userclk_active_out)
		else $error("active in helper reset");
	a_clk_hold: assert property (
		userclk_tx_reset_in [*3] |-> $stable(tx_datapath_clock_out)
			&& $stable(tx_interface_clock_out)) else $error("clock runs");
	a_src_copy: assert property (
		tx_srcclk_out == $past(tx_outclk_en_in[0])) else $error("src copy");
endmodule // trst_checker
bind trst_top trst_checker #(.PG_DELAY_CYCLES(PG_DELAY_CYCLES)) chk (.*);
`default_nettype wire

// ==== dv/trst_top_tb.sv ====
/* trst_top_tb: self-checking bench for trst_top.
   Assumes trst_chan_model on the channel side, 10 MHz clk_in. */
`timescale 1ns/1ns
`default_nettype none
module trst_top_tb;
	// =====================================================================
	// signals, design, model
	logic	clk_in, rst_in, reset_all_in, reset_tx_in, reset_rx_in;
	logic	tx_pll_lock_in, rx_pll_lock_in, rx_userclk_active_in, tx_drop;
	logic	userclk_tx_reset_in, pll_reset_out, tx_dp_reset_out, rx_drop;
	logic	rx_dp_reset_out, tx_user_ready_out, rx_user_ready_out;
	logic	tx_done_out, rx_done_out, tx_bypass_start_out, dp_q, if_q;
	logic	rx_bypass_start_out, tx_srcclk_out, tx_datapath_clock_out;
	logic	tx_interface_clock_out, tx_userclk_active_out;
	logic [trst_pkg::NUM_CH-1:0]	ch_powergood_in, tx_outclk_en_in;
	logic [trst_pkg::NUM_CH-1:0]	powergood_out;
	logic [31:0]	rs;
	int	n_fail, checks_done, passes, k, a, b;
	int	n_bp = 0, n_dp = 0, n_if = 0;
	localparam int DP_PER = 4 * trst_pkg::DP_DIV;
	trst_top #(.PG_DELAY_CYCLES(4), .TX_BUF_BYPASS(1'b1),
		.RX_BUF_BYPASS(1'b1)) uut (.*);
	trst_chan_model chan (.clk_in(clk_in), .rst_in(rst_in),
		.pll_reset_in(pll_reset_out), .tx_drop_in(tx_drop),
		.rx_drop_in(rx_drop), .ch_powergood_out(ch_powergood_in),
		.tx_lock_out(tx_pll_lock_in), .rx_lock_out(rx_pll_lock_in),
		.outclk_en_out(tx_outclk_en_in), .rx_active_out(rx_userclk_active_in));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	// count bypass pulses and user clock rises
	always @(posedge clk_in) begin
		dp_q <= tx_datapath_clock_out;
		if_q <= tx_interface_clock_out;
		n_bp <= n_bp + int'(tx_bypass_start_out === 1'b1)
			+ int'(rx_bypass_start_out === 1'b1);
		n_dp <= n_dp + int'(tx_datapath_clock_out === 1'b1 && !dp_q);
		n_if <= n_if + int'(tx_interface_clock_out === 1'b1 && !if_q);
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	function automatic int if_per();
		return DP_PER * ((trst_pkg::TX_USER_W > trst_pkg::TX_INT_W) ? 2 : 1);
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: bit %b not %b", $time, got, exp);
		end
	endtask
	task automatic chk_cnt(input int got, input int exp);
		checks_done++;
		if (got < exp - 1 || got > exp + 1) begin
			n_fail++;
			$display("wrong value at %0t: count %0d not %0d", $time, got, exp);
		end
	endtask
	// 0: both done, 1: clock active, 2: channel power good
	task automatic wait_on(input int m);
		int i;
		for (i = 0; i < 2000; i++) begin
			@(posedge clk_in);
			#1;
			if (m == 0 && tx_done_out === 1'b1 && rx_done_out === 1'b1) break;
			if (m == 1 && tx_userclk_active_out === 1'b1) break;
			if (m == 2 && &ch_powergood_in) break;
		end
		if (i == 2000) begin
			n_fail++;
			$display("wrong value at %0t: wait timed out", $time);
			wrap_up();
		end
	endtask
	task automatic req(input int r);
		@(posedge clk_in);
		reset_all_in <= (r == 0);
		reset_tx_in <= (r == 1);
		reset_rx_in <= (r == 2);
		@(posedge clk_in);
		{reset_all_in, reset_tx_in, reset_rx_in} <= 3'h0;
	endtask
	// =====================================================================
	// main sequence
	initial begin
		{rst_in, userclk_tx_reset_in} = 2'h3;
		{reset_all_in, reset_tx_in, reset_rx_in, tx_drop, rx_drop} = 5'h00;
		{n_fail, checks_done, passes} = '0;
		rs = 32'h0000003A;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		req(0); // refused, power not yet good
		wait_on(2);
		chk_bit(|powergood_out, 1'b0);
		chk_bit(pll_reset_out, 1'b1);
		chk_bit(tx_dp_reset_out & rx_dp_reset_out, 1'b1);
		@(posedge clk_in);
		userclk_tx_reset_in <= 1'b0; // source stable now
		passes = 1;
		wait_on(0);
		chk_bit(tx_user_ready_out & rx_user_ready_out, 1'b1);
		chk_bit(tx_dp_reset_out | rx_dp_reset_out, 1'b0);
		for (k = 0; k < 2; k++) begin
			@(posedge clk_in);
			tx_drop <= (k == 0);
			rx_drop <= (k == 1);
			repeat (30) @(posedge clk_in);
			#1;
			chk_bit(tx_done_out, k == 1);
			chk_bit(rx_done_out, k == 0);
			chk_bit(pll_reset_out, 1'b0);
			@(posedge clk_in);
			{tx_drop, rx_drop} <= 2'h0;
			req(k + 1);
			passes++;
			wait_on(0);
		end
		for (k = 0; k < 6; k++) begin
			rs = xs(rs);
			req(int'(rs % 3));
			if (rs[4])
				req(int'(rs[9:8]) % 3); // restart while running
			passes++;
			wait_on(0);
		end
		{a, b} = {n_dp, n_if};
		repeat (320) @(posedge clk_in);
		chk_cnt(n_dp - a, 320 / DP_PER);
		chk_cnt(n_if - b, 320 / if_per());
		@(posedge clk_in);
		userclk_tx_reset_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		#1;
		chk_bit(tx_userclk_active_out | tx_user_ready_out, 1'b0);
		@(posedge clk_in);
		userclk_tx_reset_in <= 1'b0;
		wait_on(1);
		chk_cnt(n_bp, 2 * passes);
		wrap_up();
	end
endmodule // trst_top_tb
`default_nettype wire

// ==== hw/trst_top.sv ====
/*
 * trst_top: reset sequencer for a group of transceiver channels plus the
 * transmit user-clock helper that the sequencer relies on.
 * Assumes all inputs are synchronous to clk_in; the channel source clock is
 * modelled as a one-cycle enable pulse tx_outclk_en_in from the channel.
 */
// Notes on behaviour
// RULE1: hold all resets until every channel power-good.
// RULE2: user holds resets until power reported good.
// RULE3: user waits for power-good or both done.
// RULE4: delay logic holds power-good output low initially.
// RULE5: tx done drops on tx PLL lock loss.
// RULE6: rx done drops on rx PLL lock loss.
// RULE7: no automatic restart after lock loss.
// RULE8: user-ready follows clock helpers' active status.
// RULE9: start bypass alignment when reset sequence completes.
// RULE10: tx source clock from master channel output.
// RULE11: narrow width uses one divider for both.
// RULE12: wide width: datapath clock twice interface clock.
// RULE13: each divider feeds its own channel clock.
// RULE14: helper reset holds dividers; active rises after.
// RULE15: user holds helper reset until source stable.
// RULE16: present source and both user clocks outward.
// RULE17: active indicator from short synchroniser chain.
`timescale 1ns/1ns
`default_nettype none

module trst_top #(
	parameter int unsigned PG_DELAY_CYCLES = trst_pkg::PG_DELAY_CYC,
	parameter bit          PG_DELAY_EN     = 1'b1,
	parameter bit          TX_BUF_BYPASS   = 1'b0,
	parameter bit          RX_BUF_BYPASS   = 1'b0
) (
	// clock and reset
	input  wire logic                       clk_in,
	input  wire logic                       rst_in,
	// user reset requests
	input  wire logic                       reset_all_in,
	input  wire logic                       reset_tx_in,
	input  wire logic                       reset_rx_in,
	// channel status
	input  wire logic [trst_pkg::NUM_CH-1:0] ch_powergood_in,
	input  wire logic                       tx_pll_lock_in,
	input  wire logic                       rx_pll_lock_in,
	input  wire logic                       rx_userclk_active_in,
	// channel transmit source clock enables, one per channel
	input  wire logic [trst_pkg::NUM_CH-1:0] tx_outclk_en_in,
	input  wire logic                       userclk_tx_reset_in,
	// channel reset controls
	output logic                            pll_reset_out,
	output logic                            tx_dp_reset_out,
	output logic                            rx_dp_reset_out,
	output logic                            tx_user_ready_out,
	output logic                            rx_user_ready_out,
	// status to user
	output logic [trst_pkg::NUM_CH-1:0]     powergood_out,
	output logic                            tx_done_out,
	output logic                            rx_done_out,
	output logic                            tx_bypass_start_out,
	output logic                            rx_bypass_start_out,
	// transmit user clocks
	output logic                            tx_srcclk_out,
	output logic                            tx_datapath_clock_out,
	output logic                            tx_interface_clock_out,
	output logic                            tx_userclk_active_out
);

	// =====================================================================
	// power-good hold-off
	// =====================================================================
	logic [trst_pkg::CNT_W-1:0] pgcnt_q, pgcnt_d;
	logic [trst_pkg::NUM_CH-1:0] pg_q, pg_d;
	logic all_pg;

	// count while every channel reports power good
	always_comb begin
		all_pg  = &ch_powergood_in;
		pgcnt_d = pgcnt_q;
		pg_d    = {trst_pkg::NUM_CH{1'b0}};
		if (!all_pg) begin
			pgcnt_d = '0;
		end else if (PG_DELAY_EN &&
			pgcnt_q < trst_pkg::CNT_W'(PG_DELAY_CYCLES)) begin
			pgcnt_d = pgcnt_q + trst_pkg::CNT_W'(1); // [RULE4]
		end else begin
			pg_d = ch_powergood_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pgcnt_q <= '0;
			pg_q    <= {trst_pkg::NUM_CH{trst_pkg::PG_RST}};
		end else begin
			pgcnt_q <= pgcnt_d;
			pg_q    <= pg_d;
		end
	end

	// =====================================================================
	// transmit user-clock helper
	// =====================================================================
	logic                       src_en;
	logic [trst_pkg::DIV_W-1:0] dpdiv_q, dpdiv_d;
	logic                       dpclk_q, dpclk_d;
	logic                       ifclk_q, ifclk_d;
	logic                       srcclk_q;
	logic [trst_pkg::ACT_SYNC-1:0] act_q, act_d;

	// source from the master channel; one or two dividers
	always_comb begin
		src_en  = tx_outclk_en_in[trst_pkg::MASTER_CH]; // [RULE10]
		dpdiv_d = dpdiv_q;
		dpclk_d = dpclk_q;
		ifclk_d = ifclk_q;
		act_d   = act_q;
		if (userclk_tx_reset_in) begin
			dpdiv_d = '0; // [RULE14]
			dpclk_d = 1'b0;
			ifclk_d = 1'b0;
			act_d   = '0;
		end else begin
			if (src_en) begin
				if (dpdiv_q == trst_pkg::DIV_W'(trst_pkg::DP_DIV - 1)) begin
					dpdiv_d = '0;
					dpclk_d = ~dpclk_q; // [RULE13]
					if (trst_pkg::TX_USER_W > trst_pkg::TX_INT_W) begin
						// second divider toggles on datapath rising
						if (!dpclk_q) begin
							ifclk_d = ~ifclk_q; // [RULE12]
						end
					end else begin
						ifclk_d = ~dpclk_q; // [RULE11]
					end
				end else begin
					dpdiv_d = dpdiv_q + trst_pkg::DIV_W'(1);
				end
			end
			// active chain advances on interface-clock rising edge
			if (ifclk_d && !ifclk_q) begin
				act_d = {act_q[trst_pkg::ACT_SYNC-2:0], 1'b1}; // [RULE17]
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dpdiv_q  <= '0;
			dpclk_q  <= 1'b0;
			ifclk_q  <= 1'b0;
			srcclk_q <= 1'b0;
			act_q    <= '0;
		end else begin
			dpdiv_q  <= dpdiv_d;
			dpclk_q  <= dpclk_d;
			ifclk_q  <= ifclk_d;
			srcclk_q <= src_en; // [RULE16]
			act_q    <= act_d;
		end
	end

	// =====================================================================
	// reset-all sequencer
	// =====================================================================
	trst_pkg::trst_state_e st_q, st_d;
	logic [trst_pkg::CNT_W-1:0] stcnt_q, stcnt_d;
	logic txd_q, txd_d, rxd_q, rxd_d;
	logic txb_q, txb_d, rxb_q, rxb_d;
	logic pllr_q, pllr_d, txr_q, txr_d, rxr_q, rxr_d;
	logic txu_q, txu_d, rxu_q, rxu_d;
	logic pg_ok, step_end;

	// walk one pass; done flags fall on lock loss, no restart
	always_comb begin
		pg_ok    = &pg_q;
		step_end = stcnt_q >= trst_pkg::CNT_W'(trst_pkg::STEP_CYC - 1);
		st_d     = st_q;
		stcnt_d  = stcnt_q + trst_pkg::CNT_W'(1);
		txd_d    = txd_q && tx_pll_lock_in; // [RULE5] [RULE7]
		rxd_d    = rxd_q && rx_pll_lock_in; // [RULE6] [RULE7]
		txb_d    = 1'b0;
		rxb_d    = 1'b0;
		pllr_d   = pllr_q;
		txr_d    = txr_q;
		rxr_d    = rxr_q;
		txu_d    = txu_q && tx_userclk_active_out;
		rxu_d    = rxu_q && rx_userclk_active_in;
		case (st_q)
			trst_pkg::TRST_S_WAIT_PG: begin
				pllr_d  = 1'b1;
				txr_d   = 1'b1;
				rxr_d   = 1'b1;
				stcnt_d = '0;
				if (pg_ok) begin
					st_d = trst_pkg::TRST_S_PLL_RST; // [RULE1]
				end
			end
			trst_pkg::TRST_S_PLL_RST: begin
				if (step_end) begin
					pllr_d  = 1'b0;
					stcnt_d = '0;
					st_d    = trst_pkg::TRST_S_PLL_LCK;
				end
			end
			trst_pkg::TRST_S_PLL_LCK: begin
				stcnt_d = '0;
				if (tx_pll_lock_in && rx_pll_lock_in) begin
					st_d = trst_pkg::TRST_S_DP_RST;
				end
			end
			trst_pkg::TRST_S_DP_RST: begin
				if (step_end) begin
					txr_d   = 1'b0;
					rxr_d   = 1'b0;
					stcnt_d = '0;
					st_d    = trst_pkg::TRST_S_USR_RDY;
				end
			end
			trst_pkg::TRST_S_USR_RDY: begin
				stcnt_d = '0;
				txu_d   = tx_userclk_active_out; // [RULE8]
				rxu_d   = rx_userclk_active_in; // [RULE8]
				if (txu_q && rxu_q) begin
					txd_d = tx_pll_lock_in;
					rxd_d = rx_pll_lock_in;
					txb_d = TX_BUF_BYPASS; // [RULE9]
					rxb_d = RX_BUF_BYPASS; // [RULE9]
					st_d  = trst_pkg::TRST_S_DONE;
				end
			end
			trst_pkg::TRST_S_DONE: begin
				stcnt_d = '0;
			end
			default: begin
				st_d = trst_pkg::TRST_S_WAIT_PG;
			end
		endcase
		// user request restarts the pass once power is good
		if (pg_ok && (reset_all_in || reset_tx_in || reset_rx_in)) begin
			st_d    = trst_pkg::TRST_S_PLL_RST;
			stcnt_d = '0;
			pllr_d  = 1'b1;
			txr_d   = 1'b1;
			rxr_d   = 1'b1;
			txu_d   = 1'b0;
			rxu_d   = 1'b0;
			txd_d   = 1'b0;
			rxd_d   = 1'b0;
			txb_d   = 1'b0;
			rxb_d   = 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q    <= trst_pkg::TRST_S_WAIT_PG;
			stcnt_q <= '0;
			txd_q   <= trst_pkg::DONE_RST;
			rxd_q   <= trst_pkg::DONE_RST;
			txb_q   <= 1'b0;
			rxb_q   <= 1'b0;
			pllr_q  <= 1'b1;
			txr_q   <= 1'b1;
			rxr_q   <= 1'b1;
			txu_q   <= 1'b0;
			rxu_q   <= 1'b0;
		end else begin
			st_q    <= st_d;
			stcnt_q <= stcnt_d;
			txd_q   <= txd_d;
			rxd_q   <= rxd_d;
			txb_q   <= txb_d;
			rxb_q   <= rxb_d;
			pllr_q  <= pllr_d;
			txr_q   <= txr_d;
			rxr_q   <= rxr_d;
			txu_q   <= txu_d;
			rxu_q   <= rxu_d;
		end
	end

	// =====================================================================
	// outputs, all from flip-flops
	// =====================================================================
	assign pll_reset_out          = pllr_q;
	assign tx_dp_reset_out        = txr_q;
	assign rx_dp_reset_out        = rxr_q;
	assign tx_user_ready_out      = txu_q;
	assign rx_user_ready_out      = rxu_q;
	assign powergood_out          = pg_q;
	assign tx_done_out            = txd_q;
	assign rx_done_out            = rxd_q;
	assign tx_bypass_start_out    = txb_q;
	assign rx_bypass_start_out    = rxb_q;
	assign tx_srcclk_out          = srcclk_q;
	assign tx_datapath_clock_out  = dpclk_q;
	assign tx_interface_clock_out = ifclk_q;
	assign tx_userclk_active_out  = act_q[trst_pkg::ACT_SYNC-1];

endmodule : trst_top

`default_nettype wire

// ==== pkg/trst_pkg.sv ====
/*
 * trst_pkg: shared constants for the transceiver reset sequencer and the
 * transmit user-clock helper (state codes, delays, divider settings).
 * Assumes a single 10 MHz system clock; all other rates are enable pulses.
 */
`default_nettype none

package trst_pkg;

	// =====================================================================
	// clock and timing
	// =====================================================================
	localparam int unsigned CLK_PERIOD_NS = 100;
	// power-good hold-off time, in microseconds
	localparam int unsigned PG_DELAY_US = 50;
	localparam int unsigned PG_DELAY_CYC = (PG_DELAY_US * 1000) / CLK_PERIOD_NS;
	// pulse width of each reset step, in nanoseconds
	localparam int unsigned STEP_NS = 400;
	localparam int unsigned STEP_CYC = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 16;

	// =====================================================================
	// channel and clocking configuration
	// =====================================================================
	localparam int unsigned NUM_CH = 4;
	localparam int unsigned MASTER_CH = 0;
	localparam int unsigned TX_USER_W = 64;
	localparam int unsigned TX_INT_W = 32;
	// datapath clock divides source by twice this (half-period in source enables)
	localparam int unsigned DP_DIV = 2;
	localparam int unsigned DIV_W = 4;
	localparam int unsigned ACT_SYNC = 3;

	// reset values
	localparam logic PG_RST = 1'h0;
	localparam logic DONE_RST = 1'h0;

	// =====================================================================
	// sequencer states, one-hot
	// =====================================================================
	typedef enum logic [5:0] {
		TRST_S_WAIT_PG = 6'h01,
		TRST_S_PLL_RST = 6'h02,
		TRST_S_PLL_LCK = 6'h04,
		TRST_S_DP_RST  = 6'h08,
		TRST_S_USR_RDY = 6'h10,
		TRST_S_DONE    = 6'h20
	} trst_state_e;

endpackage : trst_pkg

`default_nettype wire
